// ---- ckp_clock_pins.sv ----
/*
 * clock pin logic: apb registers, external clock pin select, oscillator
 * disables and the divided clock output on its shared pin.
 * assumes an apb master on the system clock and asynchronous pin inputs.
 */
// Local design decisions: the APB slave port and the register offsets.
`default_nettype none

module ckp_clock_pins (
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   input wire ckp_pkg::ckp_apb_req_t apbReq,
   output ckp_pkg::ckp_apb_rsp_t apbRsp,
   input wire logic defaultClockInputPin,
   input wire logic altClockInputPin,
   input wire logic gpioOut,
   input wire logic gpioOe,
   output logic externalClockInput,
   output logic crystalOscEnable,
   output logic clkoutSharedPinOut,
   output logic clkoutSharedPinOe
);
   timeunit 1ns;
   timeprecision 1ns;

   ckp_pkg::ckp_top_st_t st;
   ckp_pkg::ckp_top_st_t next_st;
   logic divClk;

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers
   function automatic logic ckpMapped(input logic [11:0] a);
      ckpMapped = (a == ckp_pkg::CKP_OFS_CFG) || (a == ckp_pkg::CKP_OFS_CTL) ||
                  (a == ckp_pkg::CKP_OFS_MUX) || (a == ckp_pkg::CKP_OFS_STATUS);
   endfunction : ckpMapped

   function automatic logic [31:0] ckpRead(input logic [11:0] a, input ckp_pkg::ckp_top_st_t s,
                                           input logic dc);
      logic [31:0] r;
      r = 32'h0;
      case (a)
         ckp_pkg::CKP_OFS_CFG: begin
            r[ckp_pkg::CKP_CFG_DIV_LSB +: 2] = s.div;
            r[ckp_pkg::CKP_CFG_PINSEL_BIT] = s.pinSel;
         end
         ckp_pkg::CKP_OFS_CTL: begin
            r[ckp_pkg::CKP_CTL_XTALOFF_BIT] = s.xtalOff;
            r[ckp_pkg::CKP_CTL_EXTOFF_BIT] = s.extOff;
         end
         ckp_pkg::CKP_OFS_MUX: begin
            r[ckp_pkg::CKP_MUX_CLK_BIT] = s.muxClk;
         end
         ckp_pkg::CKP_OFS_STATUS: begin
            r[ckp_pkg::CKP_ST_XTALEN_BIT] = s.xtalEn;
            r[ckp_pkg::CKP_ST_EXTEN_BIT] = s.extEn;
            r[ckp_pkg::CKP_ST_DEFPIN_BIT] = s.fltDef;
            r[ckp_pkg::CKP_ST_ALTPIN_BIT] = s.fltAlt;
            r[ckp_pkg::CKP_ST_DIVCLK_BIT] = dc;
         end
         default: begin
            r = 32'h0;
         end
      endcase
      ckpRead = r;
   endfunction : ckpRead

   ////////////////////////////////////////////////////////////////////////////
   // divider
   ckp_clkout_divider u_div (
      .clock(clock),
      .resetn(resetn),
      .ce(ce),
      .divSel(st.div),
      .divClk(divClk)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_st = st;
      // pin synchronisers, level taken once stages two and three agree
      next_st.syncDef = {st.syncDef[1:0], defaultClockInputPin};
      next_st.syncAlt = {st.syncAlt[1:0], altClockInputPin};
      if (st.syncDef[1] == st.syncDef[2]) begin
         next_st.fltDef = st.syncDef[2];
      end
      if (st.syncAlt[1] == st.syncAlt[2]) begin
         next_st.fltAlt = st.syncAlt[2];
      end
      // apb slave
      case (st.apbSt)
         ckp_pkg::CKP_APB_IDLE: begin
            next_st.rsp.pready = 1'h0;
            if (apbReq.psel && !apbReq.penable) begin
               next_st.apbSt = ckp_pkg::CKP_APB_RESP;
               next_st.rsp.pready = 1'h1;
               next_st.rsp.pslverr = !ckpMapped(apbReq.paddr);
               next_st.rsp.prdata = apbReq.pwrite ? 32'h0 : ckpRead(apbReq.paddr, st, divClk);
            end
         end
         ckp_pkg::CKP_APB_RESP: begin
            if (apbReq.psel && apbReq.penable) begin
               next_st.apbSt = ckp_pkg::CKP_APB_IDLE;
               next_st.rsp.pready = 1'h0;
               next_st.rsp.pslverr = 1'h0;
               if (apbReq.pwrite) begin
                  case (apbReq.paddr)
                     ckp_pkg::CKP_OFS_CFG: begin
                        next_st.div = ckp_pkg::ckp_div_t'(apbReq.pwdata[ckp_pkg::CKP_CFG_DIV_LSB +: 2]);
                        next_st.pinSel = apbReq.pwdata[ckp_pkg::CKP_CFG_PINSEL_BIT];
                     end
                     ckp_pkg::CKP_OFS_CTL: begin
                        next_st.xtalOff = apbReq.pwdata[ckp_pkg::CKP_CTL_XTALOFF_BIT];
                        next_st.extOff = apbReq.pwdata[ckp_pkg::CKP_CTL_EXTOFF_BIT];
                     end
                     ckp_pkg::CKP_OFS_MUX: begin
                        next_st.muxClk = apbReq.pwdata[ckp_pkg::CKP_MUX_CLK_BIT];
                     end
                     default: begin
                        next_st.muxClk = st.muxClk;
                     end
                  endcase
               end
            end
         end
         default: begin
            next_st.apbSt = ckp_pkg::CKP_APB_IDLE;
            next_st.rsp = '0;
         end
      endcase
      // oscillator enables and shared pin
      next_st.xtalEn = !next_st.xtalOff;
      next_st.extEn = !next_st.extOff;
      next_st.pinOut = gpioOut;
      next_st.pinOe = next_st.muxClk | gpioOe;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.apbSt <= ckp_pkg::CKP_APB_IDLE;
         st.div <= ckp_pkg::CKP_RST_DIV;
         st.pinSel <= ckp_pkg::CKP_RST_PINSEL;
         st.xtalOff <= ckp_pkg::CKP_RST_XTALOFF;
         st.extOff <= ckp_pkg::CKP_RST_EXTOFF;
         st.muxClk <= ckp_pkg::CKP_RST_MUXCLK;
         st.xtalEn <= !ckp_pkg::CKP_RST_XTALOFF;
         st.extEn <= !ckp_pkg::CKP_RST_EXTOFF;
      end else if (ce) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign apbRsp = st.rsp;
   assign crystalOscEnable = st.xtalEn;
   // clock paths pass raw clock edges (the selected input pin, and the system clock at divide by 1), gated by registered enables
   assign externalClockInput = st.extEn & (st.pinSel ? altClockInputPin : defaultClockInputPin);
   assign clkoutSharedPinOut = st.muxClk ? ((st.div == ckp_pkg::CKP_DIV1) ? (clock & divClk) : divClk)
                                         : st.pinOut;
   assign clkoutSharedPinOe = st.pinOe;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic cfgWritten;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cfgWritten <= 1'h0;
      end else if (ce && apbReq.psel && apbReq.penable && apbReq.pwrite && apbReq.paddr == ckp_pkg::CKP_OFS_CFG) begin
         cfgWritten <= 1'h1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   a_div_half_rate: assert property (ce && $past(ce) && st.div == ckp_pkg::CKP_DIV2 &&
      $past(st.div) == ckp_pkg::CKP_DIV2 |-> divClk != $past(divClk))
      else $error("half rate clock did not toggle");
   a_div_quarter_rate: assert property ((ce && st.div == ckp_pkg::CKP_DIV4 && $rose(divClk)) ##1
      (ce && st.div == ckp_pkg::CKP_DIV4) |-> divClk ##1 (ce && st.div == ckp_pkg::CKP_DIV4) |-> !divClk)
      else $error("quarter rate clock wrong");
   a_div_reset_code: assert property (!cfgWritten |-> st.div == ckp_pkg::CKP_DIV4)
      else $error("divider not quarter after reset");
   a_clkout_off: assert property (st.div == ckp_pkg::CKP_OFF && $past(st.div) == ckp_pkg::CKP_OFF && $past(ce)
      |-> !divClk && (!st.muxClk || !clkoutSharedPinOut))
      else $error("clock output not stopped");
   a_pin_mux_gpio: assert property ($past(ce) && !st.muxClk |-> clkoutSharedPinOut == $past(gpioOut))
      else $error("shared pin not carrying other function");
   a_pinsel_default: assert property (!cfgWritten |-> !st.pinSel &&
      externalClockInput == (st.extEn & defaultClockInputPin))
      else $error("default clock pin not selected");
   a_xtal_disable: assert property (ce && apbReq.psel && apbReq.penable && st.apbSt == ckp_pkg::CKP_APB_RESP &&
      apbReq.pwrite && apbReq.paddr == ckp_pkg::CKP_OFS_CTL && apbReq.pwdata[ckp_pkg::CKP_CTL_XTALOFF_BIT]
      |=> !crystalOscEnable)
      else $error("crystal not disabled");
   a_ext_disable: assert property (st.extOff |-> !externalClockInput)
      else $error("external clock path not disabled");
   a_apb_ready: assert property (ce && st.apbSt == ckp_pkg::CKP_APB_IDLE && apbReq.psel && !apbReq.penable
      |=> apbRsp.pready)
      else $error("apb answer missing");

   c_div_half: cover property (st.div == ckp_pkg::CKP_DIV2 && st.muxClk);
   c_clk_off: cover property (st.div == ckp_pkg::CKP_OFF);
   c_alt_pin: cover property (st.pinSel && st.extEn);
   c_xtal_off: cover property (!crystalOscEnable);

endmodule : ckp_clock_pins

`default_nettype wire

// ---- ckp_pkg.sv ----
/*
 * shared constants, register map, field layouts and types for the clock pin block.
 * assumes one 50 MHz system clock, an apb master and a 12-bit byte address.
 */
`default_nettype none

package ckp_pkg;
   timeunit 1ns;
   timeprecision 1ns;

   ////////////////////////////////////////////////////////////////////////////
   // register map
   localparam int CKP_AW = 12;
   localparam logic [11:0] CKP_OFS_CFG = 12'h000;
   localparam logic [11:0] CKP_OFS_CTL = 12'h004;
   localparam logic [11:0] CKP_OFS_MUX = 12'h008;
   localparam logic [11:0] CKP_OFS_STATUS = 12'h00C;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int CKP_CFG_DIV_LSB = 0;
   localparam int CKP_CFG_PINSEL_BIT = 2;
   localparam int CKP_CTL_EXTOFF_BIT = 13;
   localparam int CKP_CTL_XTALOFF_BIT = 14;
   localparam int CKP_MUX_CLK_BIT = 0;
   localparam int CKP_ST_XTALEN_BIT = 0;
   localparam int CKP_ST_EXTEN_BIT = 1;
   localparam int CKP_ST_DEFPIN_BIT = 2;
   localparam int CKP_ST_ALTPIN_BIT = 3;
   localparam int CKP_ST_DIVCLK_BIT = 4;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      CKP_DIV4 = 2'h0,
      CKP_DIV2 = 2'h1,
      CKP_DIV1 = 2'h2,
      CKP_OFF = 2'h3
   } ckp_div_t;

   typedef enum logic [1:0] {
      CKP_APB_IDLE = 2'h0,
      CKP_APB_RESP = 2'h1
   } ckp_apb_st_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ckp_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ckp_apb_rsp_t;

   ////////////////////////////////////////////////////////////////////////////
   // values after reset, and the divider toggle count
   localparam ckp_div_t CKP_RST_DIV = CKP_DIV4;
   localparam logic CKP_RST_PINSEL = 1'h0;
   localparam logic CKP_RST_XTALOFF = 1'h0;
   localparam logic CKP_RST_EXTOFF = 1'h0;
   localparam logic CKP_RST_MUXCLK = 1'h0;
   localparam logic [1:0] CKP_CNT_LAST = 2'h1;

   typedef struct packed {
      ckp_apb_st_t apbSt;
      ckp_apb_rsp_t rsp;
      ckp_div_t div;
      logic pinSel;
      logic xtalOff;
      logic extOff;
      logic muxClk;
      logic [2:0] syncDef;
      logic [2:0] syncAlt;
      logic fltDef;
      logic fltAlt;
      logic pinOut;
      logic pinOe;
      logic xtalEn;
      logic extEn;
   } ckp_top_st_t;

   typedef struct packed {
      logic [1:0] cnt;
      logic q;
   } ckp_div_st_t;

endpackage : ckp_pkg

`default_nettype wire

// ---- ckp_clkout_divider.sv ----
/*
 * divides the system clock by 4 or 2, holds it high so the caller can pass the clock, or holds it low.
 * assumes the code is registered by the caller on the same clock.
 */
`default_nettype none

module ckp_clkout_divider (
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   input wire ckp_pkg::ckp_div_t divSel,
   output logic divClk
);
   timeunit 1ns;
   timeprecision 1ns;

   ckp_pkg::ckp_div_st_t st;
   ckp_pkg::ckp_div_st_t next_st;

   ////////////////////////////////////////////////////////////////////////////
   // toggle divider
   always_comb begin
      next_st = st;
      case (divSel)
         ckp_pkg::CKP_DIV4: begin
            next_st.cnt = 2'(st.cnt + 2'h1);
            if (st.cnt[0] == ckp_pkg::CKP_CNT_LAST[0]) begin
               next_st.q = ~st.q;
            end
         end
         ckp_pkg::CKP_DIV2: begin
            next_st.cnt = 2'h0;
            next_st.q = ~st.q;
         end
         ckp_pkg::CKP_DIV1: begin
            next_st.cnt = 2'h0;
            next_st.q = 1'h1;
         end
         default: begin
            next_st.cnt = 2'h0;
            next_st.q = 1'h0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign divClk = st.q;

endmodule : ckp_clkout_divider

`default_nettype wire

// ---- ckp_osc_model.sv ----
/*
 * model of the board side: two free-running external oscillators on the
 * default and alternate clock input pins, each with its own run control.
 * assumes the bench starts and stops the oscillators as the scenarios need.
 */
`default_nettype none

module ckp_osc_model #(
   parameter int DEF_HALF = 15,
   parameter int ALT_HALF = 35
) (
   input wire logic defRun,
   input wire logic altRun,
   output logic defPin,
   output logic altPin
);
   timeunit 1ns;
   timeprecision 1ns;

   ////////////////////////////////////////////////////////////////////////////
   // fast oscillator on the default pin, stopped means held low
   initial begin
      defPin = 1'b0;
      forever begin
         #(DEF_HALF);
         defPin = defRun ? ~defPin : 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slow oscillator on the alternate pin, stopped means held low
   initial begin
      altPin = 1'b0;
      forever begin
         #(ALT_HALF);
         altPin = altRun ? ~altPin : 1'b0;
      end
   end
endmodule : ckp_osc_model

`default_nettype wire

// ---- ckp_tb_top.sv ----
/*
 * self-checking bench: apb register access, divided clock measurement,
 * shared pin mux, clock input pin select and oscillator disables.
 * assumes the oscillator model drives the clock input pins.
 */
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic clock;
   logic resetn;
   logic ce;
   ckp_pkg::ckp_apb_req_t apbReq;
   ckp_pkg::ckp_apb_rsp_t apbRsp;
   logic defPin;
   logic altPin;
   logic defRun;
   logic altRun;
   logic gpioOut;
   logic gpioOe;
   logic externalClockInput;
   logic crystalOscEnable;
   logic clkoutSharedPinOut;
   logic clkoutSharedPinOe;
   int miscompares;
   int comparisons;
   int cycles;
   int rises [4] = '{4, 8, 16, 0};

   ckp_clock_pins ckp_clock_pins_i (.clock(clock), .resetn(resetn), .ce(ce), .apbReq(apbReq), .apbRsp(apbRsp),
      .defaultClockInputPin(defPin), .altClockInputPin(altPin), .gpioOut(gpioOut), .gpioOe(gpioOe),
      .externalClockInput(externalClockInput), .crystalOscEnable(crystalOscEnable),
      .clkoutSharedPinOut(clkoutSharedPinOut), .clkoutSharedPinOe(clkoutSharedPinOe));

   ckp_osc_model ckp_osc_model_i (.defRun(defRun), .altRun(altRun), .defPin(defPin), .altPin(altPin));

   ////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial begin
      clock = 1'b0;
      forever begin
         #10;
         clock = ~clock;
      end
   end

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares = miscompares + 1;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic finish_test();
      if (miscompares == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
         output logic e);
      @(posedge clock);
      apbReq.psel <= 1'b1;
      apbReq.penable <= 1'b0;
      apbReq.pwrite <= wr;
      apbReq.paddr <= a;
      apbReq.pwdata <= d;
      @(posedge clock);
      apbReq.penable <= 1'b1;
      do @(posedge clock); while (apbRsp.pready !== 1'b1);
      r = apbRsp.prdata;
      e = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk({31'h0, e}, 32'h0);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r & mask, exp);
      chk({31'h0, e}, {31'h0, a > ckp_pkg::CKP_OFS_STATUS});
   endtask : rd

   task automatic measure(input int exp);
      int n;
      logic prev;
      n = 0;
      @(negedge clock);
      #5;
      prev = clkoutSharedPinOut;
      repeat (32) begin
         #10;
         if (clkoutSharedPinOut === 1'b1 && prev === 1'b0) n++;
         prev = clkoutSharedPinOut;
      end
      chk(32'(n), 32'(exp));
   endtask : measure

   task automatic check_ext(input logic sel, input logic en);
      repeat (8) begin
         @(negedge clock);
         #1;
         chk({31'h0, externalClockInput}, {31'h0, en & (sel ? altPin : defPin)});
      end
   endtask : check_ext

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      apbReq = '0;
      gpioOut = 1'b0;
      gpioOe = 1'b0;
      defRun = 1'b1;
      altRun = 1'b1;
      miscompares = 0;
      comparisons = 0;
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      rd(ckp_pkg::CKP_OFS_CFG, 32'h0, 32'hFFFFFFFF);
      rd(ckp_pkg::CKP_OFS_CTL, 32'h0, 32'hFFFFFFFF);
      rd(ckp_pkg::CKP_OFS_MUX, 32'h0, 32'hFFFFFFFF);
      chk({31'h0, crystalOscEnable}, 32'h1);
      check_ext(1'b0, 1'b1);
      @(posedge clock);
      gpioOut <= 1'b1;
      gpioOe <= 1'b1;
      repeat (3) @(posedge clock);
      chk({30'h0, clkoutSharedPinOut, clkoutSharedPinOe}, 32'h3);
      gpioOut <= 1'b0;
      gpioOe <= 1'b0;
      wr(ckp_pkg::CKP_OFS_MUX, 32'h1);
      measure(4);
      chk({31'h0, clkoutSharedPinOe}, 32'h1);
      for (int c = 0; c < 4; c++) begin
         wr(ckp_pkg::CKP_OFS_CFG, 32'(c));
         measure(rises[c]);
      end
      chk({31'h0, clkoutSharedPinOut}, 32'h0);
      wr(ckp_pkg::CKP_OFS_CFG, 32'h1);
      @(posedge clock);
      ce <= 1'b0;
      measure(0);
      @(posedge clock);
      ce <= 1'b1;
      measure(8);
      wr(ckp_pkg::CKP_OFS_MUX, 32'h0);
      measure(0);
      chk({31'h0, clkoutSharedPinOe}, 32'h0);
      wr(ckp_pkg::CKP_OFS_CFG, 32'h4);
      rd(ckp_pkg::CKP_OFS_CFG, 32'h4, 32'hFFFFFFFF);
      check_ext(1'b1, 1'b1);
      wr(ckp_pkg::CKP_OFS_CTL, 32'h2000);
      check_ext(1'b1, 1'b0);
      chk({31'h0, crystalOscEnable}, 32'h1);
      rd(ckp_pkg::CKP_OFS_STATUS, 32'h1, 32'h3);
      wr(ckp_pkg::CKP_OFS_CTL, 32'h4000);
      @(negedge clock);
      chk({31'h0, crystalOscEnable}, 32'h0);
      check_ext(1'b1, 1'b1);
      rd(ckp_pkg::CKP_OFS_CTL, 32'h4000, 32'hFFFFFFFF);
      rd(ckp_pkg::CKP_OFS_STATUS, 32'h2, 32'h3);
      wr(ckp_pkg::CKP_OFS_STATUS, 32'h0);
      rd(12'h010, 32'h0, 32'hFFFFFFFF);
      finish_test();
   end
endmodule : tb_top

`default_nettype wire
